// File: core/bfr_fifo.sv
/*
  bfr_fifo: parameterised word FIFO, valid/ready on both sides.
  assumes: one clock, clock enable freezes all state.
*/
`timescale 1ns/1ps
`default_nettype none
module bfr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("bfr_fifo depth must be a power of two");
  end
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } bfr_fifo_s;
  bfr_fifo_s st;
  bfr_fifo_s next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;
  assign in_ready  = (st.wr - st.rd) != (AW+1)'(DEPTH);
  assign out_valid = st.wr != st.rd;
  assign out_data  = mem[st.rd[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop  = out_valid && out_ready;
  always_comb
  begin
    next_st = st;
    if (push)
      next_st.wr = st.wr + 1'b1;
    if (pop)
      next_st.rd = st.rd + 1'b1;
  end
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      st <= '0;
    else if (clk_en)
      st <= next_st;
  end
  always_ff @(posedge core_clk)
  begin
    if (clk_en && push)
      mem[st.wr[AW-1:0]] <= in_data;
  end
endmodule : bfr_fifo
`default_nettype wire

// File: core/bfr_pkg.sv
/*
  bfr_pkg: constants for the burst flash read port.
  assumes: compiled before every other design file.
*/
package bfr_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] CONFIG_OFFSET    = 8'h00;
  localparam logic [7:0] STATUS_OFFSET    = 8'h04;
  localparam logic [7:0] WORDCOUNT_OFFSET = 8'h08;
  // config register fields
  localparam int CFG_SYNC_BIT   = 0;
  localparam int CFG_WRAP_BIT   = 1;
  localparam int CFG_RDYT_BIT   = 2;
  localparam int CFG_EDGE_BIT   = 3;
  localparam int CFG_WAIT_LSB   = 4;
  localparam int CFG_WAIT_W     = 3;
  localparam logic [31:0] CFG_RESET = 32'h0000_0055;
  // wait states
  localparam logic [2:0] WAIT_MIN = 3'h2;
  localparam logic [2:0] WAIT_MAX = 3'h7;
  // burst geometry
  localparam int BURST_LEN      = 8;
  localparam int PAGE_LEN       = 4;
  localparam logic [2:0] BOUNDARY_DELAY = 3'h1;
  // asynchronous access times
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int ACC_TIME_NS    = 80;
  localparam int PACC_TIME_NS   = 20;
  localparam int ACC_CYCLES  = (ACC_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int PACC_CYCLES = (PACC_TIME_NS * 1000) / CLK_PERIOD_PS;
endpackage : bfr_pkg

// File: core/bfr_sync.sv
/*
  bfr_sync: two-flop synchronisers for all link pins.
  assumes: pins are asynchronous to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module bfr_sync (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // raw pins
  input  wire logic        link_clk,
  input  wire logic        address_valid_strobe_n,
  input  wire logic        chip_sel_n,
  input  wire logic        out_en_n,
  input  wire logic [23:0] addr,
  // synchronised
  bfr_sync_if.src          so
);
  typedef struct packed {
    logic [27:0] s1;
    logic [27:0] s2;
  } bfr_sync_s;
  bfr_sync_s st;
  bfr_sync_s next_st;
  always_comb
  begin
    next_st    = st;
    next_st.s1 = {link_clk, address_valid_strobe_n, chip_sel_n, out_en_n, addr};
    next_st.s2 = st.s1;
  end
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      st <= {28'h700_0000, 28'h700_0000};
    else if (clk_en)
      st <= next_st;
  end
  assign so.link_clk   = st.s2[27];
  assign so.strobe_n   = st.s2[26];
  assign so.chip_sel_n = st.s2[25];
  assign so.out_en_n   = st.s2[24];
  assign so.addr       = st.s2[23:0];
endmodule : bfr_sync
`default_nettype wire

// File: core/bfr_sync_if.sv
/*
  bfr_sync_if: synchronised link inputs passed to the core.
  assumes: filled by bfr_sync, read by bfr_top.
*/
`timescale 1ns/1ps
`default_nettype none
interface bfr_sync_if;
  logic        link_clk;
  logic        strobe_n;
  logic        chip_sel_n;
  logic        out_en_n;
  logic [23:0] addr;
  modport src (output link_clk, strobe_n, chip_sel_n, out_en_n, addr);
  modport dst (input  link_clk, strobe_n, chip_sel_n, out_en_n, addr);
endinterface : bfr_sync_if
`default_nettype wire

// File: core/bfr_top.sv
/*
  bfr_top: read side of a burst NOR flash port, sync burst and async/page.
  assumes: host drives link clock, strobe, chip select, output enable;
  array words arrive through the fill FIFO from a loader; Wishbone classic.
*/
// Local design decisions: register access over Wishbone and the register addresses.
// Notes on behaviour
// - sync mode: address taken on first clock edge
// - initial wait states two to seven cycles
// - boundary addresses insert delay, shown on ready
// - wrap on: ascend then wrap within eight
// - wrap off: ascend past eight-word boundary
// - ready bit zero: ready one cycle early
// - rising link edge may be active edge
// - async mode: address taken at strobe rise
// - async page: four words by low bits
`timescale 1ns/1ps
`default_nettype none
module bfr_top (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // array word source
  input  wire logic        fill_valid,
  output logic             fill_ready,
  input  wire logic [15:0] fill_data,
  // flash pins
  input  wire logic        link_clk,
  input  wire logic        address_valid_strobe_n,
  input  wire logic        chip_sel_n,
  input  wire logic        out_en_n,
  input  wire logic [23:0] addr,
  output logic      [15:0] data_out,
  output logic             data_oe,
  output logic             ready_out,
  // fetch request to the loader
  output logic      [23:0] fetch_addr,
  output logic             fetch_req
);
  typedef enum {ST_IDLE, ST_WAIT, ST_BURST, ST_ASYNC} bfr_state_e;

  typedef struct packed {
    bfr_state_e  state;
    logic [31:0] cfg;
    logic [31:0] rdat;
    logic        ack;
    logic        clk_d;
    logic        strb_d;
    logic [23:0] base;
    logic [23:0] cur;
    logic [3:0]  wait_cnt;
    logic [2:0]  extra;
    logic [3:0]  words;
    logic [15:0] acc_cnt;
    logic [1:0]  page_lo;
    logic [15:0] dout;
    logic        oe;
    logic        rdy;
    logic        have;
    logic [15:0] hold;
    logic [23:0] faddr;
    logic        freq;
    logic [31:0] delivered;
  } bfr_top_s;

  bfr_top_s st;
  bfr_top_s next_st;

  bfr_sync_if sy ();

  logic        wd_valid;
  logic        wd_ready;
  logic [15:0] wd_data;

  bfr_sync u_sync (
    .core_clk               (core_clk),
    .reset                  (reset),
    .clk_en                 (clk_en),
    .link_clk               (link_clk),
    .address_valid_strobe_n (address_valid_strobe_n),
    .chip_sel_n             (chip_sel_n),
    .out_en_n               (out_en_n),
    .addr                   (addr),
    .so                     (sy)
  );

  // wrap arithmetic is three bits wide and page arithmetic two
  initial
  begin
    if (bfr_pkg::BURST_LEN < 2 || bfr_pkg::BURST_LEN > 8 || bfr_pkg::PAGE_LEN != 4)
      $error("bfr_top burst or page geometry unsupported");
  end

  bfr_fifo #(.WIDTH(16), .DEPTH(16)) u_fifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .clk_en    (clk_en),
    .in_valid  (fill_valid),
    .in_ready  (fill_ready),
    .in_data   (fill_data),
    .out_valid (wd_valid),
    .out_ready (wd_ready),
    .out_data  (wd_data)
  );

  logic       sync_mode;
  logic       wrap_en;
  logic       rdy_late;
  logic       rise_edge;
  logic [2:0] wait_cfg;
  logic       act_edge;
  logic       strb_rise;
  logic       sel;
  logic       wb_req;
  logic       group_cross;

  assign sync_mode = st.cfg[bfr_pkg::CFG_SYNC_BIT];
  assign wrap_en   = st.cfg[bfr_pkg::CFG_WRAP_BIT];
  assign rdy_late  = st.cfg[bfr_pkg::CFG_RDYT_BIT];
  assign rise_edge = st.cfg[bfr_pkg::CFG_EDGE_BIT];
  assign wait_cfg  = st.cfg[bfr_pkg::CFG_WAIT_LSB +: bfr_pkg::CFG_WAIT_W];
  // either link edge can be the active one
  assign act_edge  = rise_edge ? (sy.link_clk && !st.clk_d)
                               : (!sy.link_clk && st.clk_d);
  assign strb_rise = sy.strobe_n && !st.strb_d;
  // crossing the aligned group from a start at +1..+3 costs a delay
  assign group_cross = !wrap_en && st.cur[2:0] == 3'h7 && st.base[2:0] != 3'h0
                       && st.base[2:0] < 3'h4;
  assign sel       = !sy.chip_sel_n;
  assign wb_req    = wb_cyc_i && wb_stb_i && !st.ack;
  // pull one word when we have room in the hold slot
  assign wd_ready  = !st.have;

  always_comb
  begin
    next_st       = st;
    next_st.clk_d = sy.link_clk;
    next_st.strb_d = sy.strobe_n;
    next_st.ack   = wb_req;
    next_st.freq  = 1'b0;
    if (wd_valid && wd_ready)
    begin
      next_st.have = 1'b1;
      next_st.hold = wd_data;
    end
    // register access
    if (wb_req)
    begin
      next_st.rdat = 32'h0000_0000;
      case (wb_adr_i)
        bfr_pkg::CONFIG_OFFSET:
        begin
          next_st.rdat = st.cfg;
          if (wb_we_i && wb_sel_i[0])
          begin
            next_st.cfg[7:0] = wb_dat_i[7:0];
            // out-of-range wait counts are clamped
            if (wb_dat_i[6:4] < bfr_pkg::WAIT_MIN)
              next_st.cfg[6:4] = bfr_pkg::WAIT_MIN;
          end
        end
        bfr_pkg::STATUS_OFFSET:
          next_st.rdat = {26'h0, st.have, st.rdy, st.oe, 3'(st.state)};
        bfr_pkg::WORDCOUNT_OFFSET:
          next_st.rdat = st.delivered;
        default:
          next_st.rdat = 32'h0000_0000;
      endcase
    end
    if (!sel || sy.out_en_n)
      next_st.oe = 1'b0;
    case (st.state)
      ST_IDLE:
      begin
        // ready stays low until a word is due, so the host never samples idle data
        next_st.rdy = 1'b0;
        if (sel && sync_mode && !sy.strobe_n && act_edge)
        begin
          next_st.base     = sy.addr;
          next_st.extra    = 3'h0;
          next_st.cur      = sy.addr;
          next_st.faddr    = sy.addr;
          next_st.freq     = 1'b1;
          next_st.wait_cnt = {1'b0, wait_cfg};
          next_st.words    = 4'h0;
          next_st.rdy      = 1'b0;
          next_st.state    = ST_WAIT;
        end
        else if (sel && !sync_mode && strb_rise)
        begin
          next_st.base    = sy.addr;
          next_st.faddr   = sy.addr;
          next_st.freq    = 1'b1;
          next_st.page_lo = sy.addr[1:0];
          next_st.acc_cnt = 16'(bfr_pkg::ACC_CYCLES);
          next_st.state   = ST_ASYNC;
        end
      end
      ST_WAIT:
      begin
        if (!sel)
          next_st.state = ST_IDLE;
        else if (act_edge)
        begin
          if (st.wait_cnt > 4'h1)
            next_st.wait_cnt = st.wait_cnt - 4'h1;
          else
            next_st.state = ST_BURST;
          // early ready timing leads the first word by one edge
          next_st.rdy = !rdy_late && st.wait_cnt == 4'h1;
        end
      end
      ST_BURST:
      begin
        if (!sel)
          next_st.state = ST_IDLE;
        else if (act_edge)
        begin
          if (st.words == 4'(bfr_pkg::BURST_LEN))
          begin
            // all words out: nothing more was fetched, so nothing is left behind
            next_st.rdy   = 1'b0;
            next_st.state = ST_IDLE;
          end
          else if (st.extra != 3'h0)
          begin
            // boundary delay cycle; early ready already announces the next word
            next_st.extra = st.extra - 3'h1;
            next_st.rdy   = !rdy_late && st.extra == 3'h1;
          end
          else if (st.have)
          begin
            next_st.dout      = st.hold;
            next_st.oe        = !sy.out_en_n;
            next_st.have      = 1'b0;
            next_st.rdy       = 1'b1;
            next_st.words     = st.words + 4'h1;
            next_st.delivered = st.delivered + 32'h0000_0001;
            if (wrap_en)
              next_st.cur = {st.cur[23:3], 3'(st.cur[2:0] + 3'h1)};
            else
              next_st.cur = st.cur + 24'h00_0001;
            // fetch only the words this burst still owes
            if (st.words < 4'(bfr_pkg::BURST_LEN - 1))
            begin
              next_st.faddr = next_st.cur;
              next_st.freq  = 1'b1;
            end
            if (group_cross)
              next_st.extra = bfr_pkg::BOUNDARY_DELAY;
            // early ready is high only when the next edge brings a word
            if (!rdy_late && (group_cross || st.words == 4'(bfr_pkg::BURST_LEN - 1)))
              next_st.rdy = 1'b0;
          end
          else
            next_st.rdy = 1'b0;
        end
      end
      ST_ASYNC:
      begin
        if (!sel)
          next_st.state = ST_IDLE;
        else
        begin
          // page hit: low two bits change, shorter access
          if (sy.addr[23:2] == st.base[23:2] && sy.addr[1:0] != st.page_lo)
          begin
            next_st.page_lo = sy.addr[1:0];
            next_st.faddr   = sy.addr;
            next_st.freq    = 1'b1;
            next_st.acc_cnt = 16'(bfr_pkg::PACC_CYCLES);
          end
          else if (st.acc_cnt != 16'h0)
            next_st.acc_cnt = st.acc_cnt - 16'h1;
          else if (st.have)
          begin
            next_st.dout      = st.hold;
            next_st.have      = 1'b0;
            next_st.oe        = !sy.out_en_n;
            next_st.delivered = st.delivered + 32'h0000_0001;
          end
          if (strb_rise)
            next_st.state = ST_IDLE;
        end
      end
      default:
        next_st.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      st       <= '0;
      st.state <= ST_IDLE;
      st.cfg   <= bfr_pkg::CFG_RESET;
      st.clk_d <= 1'b0;
      st.strb_d <= 1'b1;
    end
    else if (clk_en)
      st <= next_st;
  end

  assign wb_dat_o   = st.rdat;
  assign wb_ack_o   = st.ack;
  assign data_out   = st.dout;
  assign data_oe    = st.oe;
  assign ready_out  = st.rdy;
  assign fetch_addr = st.faddr;
  assign fetch_req  = st.freq;
endmodule : bfr_top
`default_nettype wire

// File: testbench/bfr_host_model.sv
/*
  bfr_host_model: host controller on the flash pins; link clock runs only in accesses.
  assumes: access task called by the bench, one at a time, rising edge active.
*/
`timescale 1ns/1ps
`default_nettype none
module bfr_host_model (
  // from the device
  input  wire logic [15:0] data_out,
  input  wire logic        ready_out,
  // to the device
  output var  logic        link_clk,
  output var  logic        address_valid_strobe_n,
  output var  logic        chip_sel_n,
  output var  logic        out_en_n,
  output var  logic [23:0] addr
);
  logic [15:0] seen[$];
  logic        rdy[$];
  initial
  begin
    link_clk = 1'b0;
    address_valid_strobe_n = 1'b1;
    chip_sel_n = 1'b1;
    out_en_n = 1'b1;
    addr = 24'h00_0000;
  end
  // offset keeps link edges away from core clock edges
  task automatic access(input logic [23:0] a, input bit sync, input int n, input bit early);
    logic was;
    was = 1'b0;
    #1.3;
    chip_sel_n = 1'b0;
    out_en_n = 1'b0;
    addr = a;
    address_valid_strobe_n = 1'b0;
    if (sync)
    begin
      repeat (n)
      begin
        #16 link_clk = 1'b1;
        rdy.push_back(ready_out);
        // early ready announces the word of the following edge
        if ((early ? was : ready_out) === 1'b1) seen.push_back(data_out);
        was = ready_out;
        #16 address_valid_strobe_n = 1'b1;
        addr = ~addr; // hold over: no stale address
        #16 link_clk = 1'b0;
        #16;
      end
    end
    else
    begin
      #24 address_valid_strobe_n = 1'b1;
      for (int k = 0; k < n; k++)
      begin
        addr = {a[23:2], a[1:0] + 2'(k)};
        #150 seen.push_back(data_out);
      end
    end
    chip_sel_n = 1'b1;
    out_en_n = 1'b1;
    #200;
  endtask : access
endmodule : bfr_host_model
`default_nettype wire

// File: testbench/bfr_top_asserts.sv
/*
  bfr_top_asserts: port-level checks on bfr_top, attached by bind.
  assumes: clk_en held high by the bench; one access at a time on the pins.
*/
`timescale 1ns/1ps
`default_nettype none
module bfr_top_asserts (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // bus
  input  wire logic wb_cyc_i,
  input  wire logic wb_stb_i,
  input  wire logic wb_ack_o,
  // pins
  input  wire logic address_valid_strobe_n,
  input  wire logic chip_sel_n,
  input  wire logic out_en_n,
  input  wire logic data_oe,
  input  wire logic ready_out,
  input  wire logic fetch_req
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_idle_after_reset: assert property ($past(reset) |-> !wb_ack_o && !fetch_req && !data_oe)
    else $error("outputs active after reset");
  a_wait_floor: assert property ($fell(address_valid_strobe_n) |-> !ready_out [*8])
    else $error("ready too soon after strobe");
  a_fetch_on_capture: assert property (
    $fell(address_valid_strobe_n) && !chip_sel_n |-> ##[1:60] fetch_req)
    else $error("address not taken after strobe");
  a_deselect_idle: assert property ($rose(chip_sel_n) |-> ##[1:6] !ready_out)
    else $error("ready stays after deselect");
  a_oe_pin_off: assert property (out_en_n [*6] |-> !data_oe)
    else $error("driving while output enable high");
endmodule : bfr_top_asserts
bind bfr_top bfr_top_asserts u_chk (.core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .address_valid_strobe_n(address_valid_strobe_n),
  .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .data_oe(data_oe), .ready_out(ready_out),
  .fetch_req(fetch_req));
`default_nettype wire

// File: testbench/bfr_top_test.sv
/*
  bfr_top_test: self-checking bench for bfr_top with host model and word loader.
  assumes: bfr_top_asserts bound; bfr_host_model drives the pins.
*/
`timescale 1ns/1ps
`default_nettype none
module bfr_top_test;
  logic        core_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fill_valid, fill_ready;
  logic        link_clk, address_valid_strobe_n, chip_sel_n, out_en_n, data_oe, ready_out;
  logic        fetch_req, stuff;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [15:0] fill_data, data_out;
  logic [23:0] addr, fetch_addr, fq[$], a;
  logic [15:0] pend[$];
  int          num_errors, n_compared;
  bfr_top uut (.core_clk(core_clk), .reset(reset), .clk_en(1'b1), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fill_valid(fill_valid),
    .fill_ready(fill_ready), .fill_data(fill_data), .link_clk(link_clk),
    .address_valid_strobe_n(address_valid_strobe_n), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .addr(addr), .data_out(data_out), .data_oe(data_oe),
    .ready_out(ready_out), .fetch_addr(fetch_addr), .fetch_req(fetch_req));
  bfr_host_model host (.data_out(data_out), .ready_out(ready_out), .link_clk(link_clk),
    .address_valid_strobe_n(address_valid_strobe_n), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .addr(addr));
  always #2.5 core_clk = ~core_clk;
  function automatic logic [15:0] word_of(input logic [23:0] x);
    return x[15:0] ^ 16'h3c5a;
  endfunction : word_of
  // loader: answers each fetch with the word of that address
  always @(posedge core_clk)
  begin
    if (fill_valid === 1'b1 && fill_ready === 1'b1 && pend.size() != 0) void'(pend.pop_front());
    if (fetch_req === 1'b1)
    begin
      fq.push_back(fetch_addr);
      pend.push_back(word_of(fetch_addr));
    end
    fill_valid <= stuff || pend.size() != 0;
    fill_data <= pend.size() != 0 ? pend[0] : 16'h0000;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, ad, d, 4'hf};
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1 && n < 50)
    begin
      @(posedge core_clk);
      n++;
    end
    q = wb_dat_o;
    if (n >= 50)
    begin
      num_errors++;
      report_and_stop();
    end
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb
  task automatic run_burst(input logic [23:0] s, input logic [2:0] wt, input bit wr, input bit rt);
    logic [23:0] e;
    int          f, last, gaps;
    wb(1'b1, 8'h00, {25'h0, wt, 1'b1, rt, wr, 1'b1});
    wb(1'b0, 8'h00, 32'h0);
    chk(q, {25'h0, wt, 1'b1, rt, wr, 1'b1});
    fq.delete();
    host.seen.delete();
    host.rdy.delete();
    host.access(s, 1'b1, 22, !rt);
    chk(32'(fq.size()), 32'h0000_0008);
    chk(32'(host.seen.size()), 32'h0000_0008);
    for (int i = 0; i < 8; i++)
    begin
      e = wr ? {s[23:3], s[2:0] + 3'(i)} : s + 24'(i);
      chk({8'h0, fq[i]}, {8'h0, e});
      chk(host.seen[i], word_of(e));
    end
    f = -1;
    gaps = 0;
    foreach (host.rdy[i])
      if (host.rdy[i] === 1'b1)
      begin
        if (f < 0) f = i;
        else gaps += i - last - 1;
        last = i;
      end
    chk(f, wt + 1 + rt);
    chk(gaps, !wr && s[2:0] inside {[1:3]});
  endtask : run_burst
  initial
  begin
    {core_clk, reset, stuff} = 3'b010;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = 47'h0;
    void'($urandom(18930));
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    stuff <= 1'b1;
    repeat (24) @(posedge core_clk);
    chk(fill_ready, 1'b0);
    stuff <= 1'b0;
    reset <= 1'b1;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0000_0055);
    wb(1'b1, 8'h0c, 32'hffff_ffff);
    wb(1'b0, 8'h0c, 32'h0);
    chk(q, 32'h0000_0000);
    wb(1'b1, 8'h00, 32'h0000_0001);
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0000_0021);
    // link at 64 ns needs three wait states or more
    for (int i = 0; i < 12; i++)
    begin
      a = 24'($urandom);
      if (i < 3) a[2:0] = 3'(i + 1);
      run_burst(a, i == 0 ? 3'h3 : i == 1 ? 3'h7 : 3'(3 + $urandom % 5),
                i >= 3 && $urandom % 2, i != 4);
    end
    wb(1'b1, 8'h00, 32'h0000_0050);
    host.seen.delete();
    a = 24'($urandom);
    host.access(a, 1'b0, 4, 1'b0);
    for (int k = 0; k < 4; k++) chk(host.seen[k], word_of({a[23:2], a[1:0] + 2'(k)}));
    // twelve bursts of eight words and one page of four
    wb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h0000_0064);
    report_and_stop();
  end
endmodule : bfr_top_test
`default_nettype wire
